// ===== core/dsad_params.svh
// Constants for the data space address decoder
`ifndef DSAD_PARAMS_SVH
`define DSAD_PARAMS_SVH
`define DSAD_PC_RESET 23'h000000
`define DSAD_VEC_LIMIT 24'h000200
`define DSAD_VEC_BASE 23'h000004
`define DSAD_VEC_ALT_BASE 23'h000104
`define DSAD_SPECIAL_TOP 16'h0800
`define DSAD_NEAR_TOP 16'h2000
`define DSAD_DATA_TOP 16'h7800
`define DSAD_RAM_WORDS 14336
`define DSAD_Y_BASE 16'h4800
`define DSAD_RAM_IDX_W 14
`endif

// ===== core/dsad_pkg.sv
// Types for the data space address decoder
package dsad_pkg;
  typedef enum logic [1:0] {SRC_PTR = 2'h0, SRC_NEAR = 2'h1, SRC_FAR = 2'h3} dsad_src_type;
  typedef enum logic [1:0] {MOD_NONE = 2'h0, MOD_INC = 2'h1, MOD_DEC = 2'h3} dsad_mod_type;
  typedef enum logic [1:0] {
    REGION_SPECIAL = 2'h0,
    REGION_RAM = 2'h1,
    REGION_NONE = 2'h3,
    REGION_VIEW = 2'h2
  } dsad_region_type;
endpackage

// ===== core/dsad_lane_ram.sv
// Byte-lane data memory with X and Y read ports and one write port
`timescale 1ns/1ns
module dsad_lane_ram #(
  parameter int WORDS = 14336,
  parameter int IDX_W = 14
) (
  // Clock
  input wire logic clk,
  // Read ports
  input wire logic [IDX_W-1:0] x_idx,
  input wire logic [IDX_W-1:0] y_idx,
  output logic [15:0] x_word,
  output logic [15:0] y_word,
  // Write port
  input wire logic [IDX_W-1:0] w_idx,
  input wire logic [1:0] w_be,
  input wire logic [15:0] w_data
);
  logic [7:0] lane_lo [0:WORDS-1];
  logic [7:0] lane_hi [0:WORDS-1];

  // Two reads each have their own word index, so X and Y fetch in one cycle
  assign x_word = {lane_hi[x_idx], lane_lo[x_idx]};
  assign y_word = {lane_hi[y_idx], lane_lo[y_idx]};

  // Each lane has its own strobe; even byte is the low lane
  always_ff @(posedge clk) begin
    if (w_be[0]) begin
      lane_lo[w_idx] <= w_data[7:0];
    end
    if (w_be[1]) begin
      lane_hi[w_idx] <= w_data[15:8];
    end
  end
endmodule

// ===== core/dsad_decoder.sv
// Program and data space address decoder with byte lanes and misalignment trap
`timescale 1ns/1ns
`include "dsad_params.svh"
module dsad_decoder #(
  parameter int RAM_WORDS = `DSAD_RAM_WORDS,
  parameter logic [15:0] Y_BASE = `DSAD_Y_BASE
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Program counter control
  input wire logic pc_step,
  input wire logic pc_down,
  input wire logic jump_take,
  input wire logic [22:0] jump_addr,
  input wire logic vec_take,
  input wire logic vec_alt,
  input wire logic [6:0] vec_num,
  // Program memory
  input wire logic [15:0] prog_lo_data,
  input wire logic [15:0] prog_hi_data,
  output logic [23:0] prog_lo_addr,
  output logic [23:0] prog_hi_addr,
  output logic [23:0] instr_word,
  // X access request
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic acc_byte,
  input wire dsad_pkg::dsad_src_type ea_src,
  input wire logic [15:0] source_pointer_reg,
  input wire logic [15:0] direct_addr,
  input wire logic [15:0] wr_data,
  // Pointer update
  input wire dsad_pkg::dsad_mod_type post_mod,
  input wire logic mod_en,
  input wire logic [15:0] mod_start,
  input wire logic [15:0] mod_end,
  input wire logic bitrev_en,
  input wire logic [15:0] bitrev_step,
  output logic [15:0] ptr_out,
  // Y read request
  input wire logic y_valid,
  input wire logic [15:0] y_addr,
  // Special register bus
  input wire logic [15:0] special_func_reg_rdata,
  input wire logic special_func_reg_hit,
  output logic [15:0] special_func_reg_addr,
  output logic [15:0] special_func_reg_wdata,
  output logic [1:0] special_func_reg_be,
  // Working register byte load
  input wire logic work_reg_load,
  output logic [1:0] work_reg_be,
  // Program view window
  input wire logic [15:0] prog_view_rdata,
  output logic prog_view_sel,
  output logic [14:0] prog_view_addr,
  // Read results and trap
  output logic [15:0] x_rdata,
  output logic [15:0] y_rdata,
  output logic rd_valid,
  output logic addr_err
);
  import dsad_pkg::*;

  localparam int IW = `DSAD_RAM_IDX_W;

  // Region of a byte address; the top bit always goes to the window
  function automatic dsad_region_type region_of(input logic [15:0] a);
    if (a[15]) begin
      return REGION_VIEW;
    end else if (a < `DSAD_SPECIAL_TOP) begin
      return REGION_SPECIAL;
    end else if (a < `DSAD_DATA_TOP) begin
      return REGION_RAM;
    end else begin
      return REGION_NONE;
    end
  endfunction

  // Word index into the memory array behind the special register area
  function automatic logic [IW-1:0] ram_idx(input logic [15:0] a);
    logic [15:0] d;
    d = a - `DSAD_SPECIAL_TOP;
    return d[IW:1];
  endfunction

  // Bit order reversal for reverse-carry stepping
  function automatic logic [15:0] bit_rev(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15-i];
    end
    return r;
  endfunction

  // Program counter; bit 0 is kept clear so it sits on the lower word
  logic [22:0] pc;
  logic [22:0] next_pc;
  logic [22:0] vec_addr;
  assign vec_addr = (vec_alt ? `DSAD_VEC_ALT_BASE : `DSAD_VEC_BASE) + {15'h0000, vec_num, 1'b0};

  // Vector entry wins, then a jump, then sequential stepping
  always_comb begin
    next_pc = pc;
    if (vec_take) begin
      next_pc = vec_addr;
    end else if (jump_take) begin
      next_pc = {jump_addr[22:1], 1'b0};
    end else if (pc_step) begin
      next_pc = pc_down ? pc - 23'h000002 : pc + 23'h000002;
    end
  end

  // Reset returns to the reset vector where the user's jump sits
  always_ff @(posedge clk) begin
    if (reset) begin
      pc <= `DSAD_PC_RESET;
    end else begin
      pc <= next_pc;
    end
  end

  // Lower word even, upper word odd; upper byte of upper word dropped
  always_ff @(posedge clk) begin
    if (reset) begin
      prog_lo_addr <= 24'h000000;
      prog_hi_addr <= 24'h000001;
      instr_word <= 24'h000000;
    end else begin
      prog_lo_addr <= {1'b0, next_pc};
      prog_hi_addr <= {1'b0, next_pc[22:1], 1'b1};
      instr_word <= {prog_hi_data[7:0], prog_lo_data};
    end
  end

  // Effective address: near field, far field or pointer
  wire [15:0] effective_addr = (ea_src == SRC_NEAR) ? {3'h0, direct_addr[12:0]} :
                               (ea_src == SRC_FAR) ? direct_addr : source_pointer_reg;
  wire dsad_region_type x_region = region_of(effective_addr);
  wire misalign = acc_valid && !acc_byte && effective_addr[0];
  wire do_read = acc_valid && !acc_write;
  wire do_write = acc_valid && acc_write && !misalign;
  // Byte writes pick one lane by address bit 0
  wire [1:0] lane_be = acc_byte ? (effective_addr[0] ? 2'b10 : 2'b01) : 2'b11;
  wire [15:0] lane_data = acc_byte ? {wr_data[7:0], wr_data[7:0]} : wr_data;
  // Writes land on the combined range through the X write bus
  wire [1:0] ram_be = (do_write && x_region == REGION_RAM) ? lane_be : 2'b00;
  wire [1:0] reg_be = (do_write && x_region == REGION_SPECIAL) ? lane_be : 2'b00;

  // Y reads only hit the fixed Y range; anything else reads zero
  wire y_hit = y_valid && !y_addr[0] && y_addr >= Y_BASE && y_addr < `DSAD_DATA_TOP;

  // First read stage: decode registered, memory read from the held index
  logic s1_valid;
  logic s1_byte;
  logic s1_lane;
  dsad_region_type s1_region;
  logic [IW-1:0] s1_idx;
  logic y1_valid;
  logic y1_hit;
  logic [IW-1:0] y1_idx;
  logic [15:0] ram_x_word;
  logic [15:0] ram_y_word;

  dsad_lane_ram #(
    .WORDS(RAM_WORDS),
    .IDX_W(IW)
  ) u_ram (
    .clk(clk),
    .x_idx(s1_idx),
    .y_idx(y1_idx),
    .x_word(ram_x_word),
    .y_word(ram_y_word),
    .w_idx(ram_idx(effective_addr)),
    .w_be(ram_be),
    .w_data(lane_data)
  );

  // Request stage; a misaligned read still completes as the even word
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_valid <= 1'b0;
      s1_byte <= 1'b0;
      s1_lane <= 1'b0;
      s1_region <= REGION_NONE;
      s1_idx <= '0;
      y1_valid <= 1'b0;
      y1_hit <= 1'b0;
      y1_idx <= '0;
    end else begin
      s1_valid <= do_read;
      s1_byte <= acc_byte;
      s1_lane <= effective_addr[0];
      s1_region <= x_region;
      s1_idx <= ram_idx(effective_addr);
      y1_valid <= y_valid;
      y1_hit <= y_hit;
      y1_idx <= ram_idx(y_addr);
    end
  end

  // Outside bus strobes; the error flag is high in the cycle after each detection cycle, and low otherwise
  always_ff @(posedge clk) begin
    if (reset) begin
      special_func_reg_addr <= 16'h0000;
      special_func_reg_wdata <= 16'h0000;
      special_func_reg_be <= 2'b00;
      prog_view_sel <= 1'b0;
      prog_view_addr <= 15'h0000;
      addr_err <= 1'b0;
    end else begin
      special_func_reg_addr <= {effective_addr[15:1], 1'b0};
      special_func_reg_wdata <= lane_data;
      special_func_reg_be <= reg_be;
      prog_view_sel <= do_read && x_region == REGION_VIEW;
      prog_view_addr <= effective_addr[14:0];
      addr_err <= misalign;
    end
  end

  // Word seen by the X read bus; absent locations give zero
  wire [15:0] x_word = (s1_region == REGION_RAM) ? ram_x_word :
                       (s1_region == REGION_VIEW) ? prog_view_rdata :
                       (s1_region == REGION_SPECIAL && special_func_reg_hit) ?
                       special_func_reg_rdata : 16'h0000;
  // Byte reads put the chosen byte on the low lane
  wire [15:0] x_out = !s1_byte ? x_word :
                      {8'h00, s1_lane ? x_word[15:8] : x_word[7:0]};

  // Result stage: both read buses answer together
  always_ff @(posedge clk) begin
    if (reset) begin
      x_rdata <= 16'h0000;
      y_rdata <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      x_rdata <= s1_valid ? x_out : 16'h0000;
      y_rdata <= y1_hit ? ram_y_word : 16'h0000;
      rd_valid <= s1_valid || y1_valid;
    end
  end

  // Byte loads into a working register keep its high byte
  always_ff @(posedge clk) begin
    if (reset) begin
      work_reg_be <= 2'b00;
    end else begin
      work_reg_be <= !work_reg_load ? 2'b00 : (acc_byte ? 2'b01 : 2'b11);
    end
  end

  // Pointer arithmetic scaled by size, with modulo wrap
  wire [15:0] step = acc_byte ? 16'h0001 : 16'h0002;
  wire [15:0] ptr_inc = source_pointer_reg + step;
  wire [15:0] ptr_dec = source_pointer_reg - step;
  wire [15:0] rev_sum = bit_rev(bit_rev(source_pointer_reg) + bit_rev(bitrev_step));
  // Reverse carry only for X writes; it costs the modulo option there
  wire use_rev = bitrev_en && acc_write && post_mod == MOD_INC;
  logic [15:0] next_ptr;
  always_comb begin
    next_ptr = source_pointer_reg;
    if (use_rev) begin
      next_ptr = rev_sum;
    end else if (post_mod == MOD_INC) begin
      next_ptr = (mod_en && source_pointer_reg >= mod_end) ? mod_start : ptr_inc;
    end else if (post_mod == MOD_DEC) begin
      next_ptr = (mod_en && source_pointer_reg <= mod_start) ? mod_end : ptr_dec;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ptr_out <= 16'h0000;
    end else if (acc_valid) begin
      ptr_out <= next_ptr;
    end
  end

  // Checks
  sequence s_byte_read;
    acc_valid && !acc_write && acc_byte;
  endsequence
  sequence s_bad_write;
    misalign && acc_write;
  endsequence

  property p_pc_even;
    @(posedge clk) disable iff (reset) !pc[0] && !prog_lo_addr[0];
  endproperty
  a_pc_even: assert property (p_pc_even) else $error("pc off lower word");
  property p_pc_step;
    @(posedge clk) disable iff (reset)
      pc_step && !pc_down && !vec_take && !jump_take |=> pc == $past(pc) + 23'h000002;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc step not two");
  property p_reset_pc;
    @(posedge clk) reset |=> prog_lo_addr == 24'h000000;
  endproperty
  a_reset_pc: assert property (p_reset_pc) else $error("reset not at zero");
  property p_vec;
    @(posedge clk) disable iff (reset)
      vec_take && !vec_alt |=> pc == 23'h000004 + {15'h0000, $past(vec_num), 1'b0};
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector entry");
  property p_hi_addr;
    @(posedge clk) disable iff (reset) prog_hi_addr == (prog_lo_addr | 24'h000001);
  endproperty
  a_hi_addr: assert property (p_hi_addr) else $error("upper word not odd");
  property p_err;
    @(posedge clk) disable iff (reset) misalign |=> addr_err;
  endproperty
  a_err: assert property (p_err) else $error("no address error");
  property p_err_pulse;
    @(posedge clk) disable iff (reset) !misalign |=> !addr_err;
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("spurious error");
  property p_no_wr;
    @(posedge clk) disable iff (reset)
      s_bad_write |-> ram_be == 2'b00 ##1 special_func_reg_be == 2'b00;
  endproperty
  a_no_wr: assert property (p_no_wr) else $error("misaligned write done");
  property p_byte_rd;
    @(posedge clk) disable iff (reset) s_byte_read |-> ##2 rd_valid && x_rdata[15:8] == 8'h00;
  endproperty
  a_byte_rd: assert property (p_byte_rd) else $error("byte not on low lane");
  property p_unimpl;
    @(posedge clk) disable iff (reset)
      do_read && x_region == REGION_NONE |-> ##2 x_rdata == 16'h0000;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("absent location not zero");
  property p_ptr;
    @(posedge clk) disable iff (reset)
      acc_valid && acc_byte && post_mod == MOD_INC && !mod_en && !bitrev_en
      |=> ptr_out == $past(source_pointer_reg) + 16'h0001;
  endproperty
  a_ptr: assert property (p_ptr) else $error("byte step not one");
  property p_work;
    @(posedge clk) disable iff (reset) work_reg_load && acc_byte |=> work_reg_be == 2'b01;
  endproperty
  a_work: assert property (p_work) else $error("byte load hit high byte");
  property p_view;
    @(posedge clk) disable iff (reset)
      do_read && effective_addr[15] |=> prog_view_sel;
  endproperty
  a_view: assert property (p_view) else $error("window not selected");
endmodule

// ===== verif/dsad_far_model.sv
// Far-side model: program memory, special register responder, program view window
`timescale 1ns/1ns
module dsad_far_model (
  // Clock
  input wire logic clk,
  // Program memory
  input wire logic [23:0] prog_lo_addr,
  input wire logic [23:0] prog_hi_addr,
  output logic [15:0] prog_lo_data,
  output logic [15:0] prog_hi_data,
  // Special register bus
  input wire logic [15:0] special_func_reg_addr,
  input wire logic [15:0] special_func_reg_wdata,
  input wire logic [1:0] special_func_reg_be,
  output logic [15:0] special_func_reg_rdata,
  output logic special_func_reg_hit,
  // Program view window
  input wire logic prog_view_sel,
  output logic [15:0] prog_view_rdata
);
  logic [15:0] regs [16];
  logic [15:0] churn = 16'h1357;
  logic [3:0] ridx;
  logic [1:0] we;
  // Only sixteen registers answer; the rest of the area stays silent
  assign special_func_reg_hit = special_func_reg_addr < 16'h0020;
  assign ridx = special_func_reg_addr[4:1];
  assign we = special_func_reg_be & {2{special_func_reg_hit}};
  // Absent top byte of the upper word carries junk
  assign prog_lo_data = prog_lo_addr[15:0] ^ 16'h3c5a;
  assign prog_hi_data = {8'hee, prog_hi_addr[7:0] ^ 8'h96};
  // Unanswered lines move every cycle so a stale value cannot pass as a match
  assign special_func_reg_rdata = special_func_reg_hit ? regs[ridx] : churn;
  assign prog_view_rdata = prog_view_sel ? 16'h5a3c : ~churn;
  initial begin
    foreach (regs[i]) regs[i] = 16'h0000;
  end
  // Each strobe writes its own lane only
  always @(posedge clk) begin
    churn <= {churn[14:0], churn[15] ^ churn[12]};
    if (we[0]) regs[ridx][7:0] <= special_func_reg_wdata[7:0];
    if (we[1]) regs[ridx][15:8] <= special_func_reg_wdata[15:8];
  end
endmodule

// ===== verif/data_space_address_decoder_bench.sv
// Self-checking bench for the data space address decoder
`timescale 1ns/1ns
`include "dsad_params.svh"
module data_space_address_decoder_bench;
  import dsad_pkg::*;
  typedef struct {int stamp; logic err; logic cp; logic [15:0] ptr; logic [23:0] lo;
    logic [23:0] instr; logic [1:0] wbe; logic [14:0] pv; logic [1:0] sbe;} dsad_step_type;
  typedef struct {int stamp; logic cy; logic [15:0] x; logic [15:0] y;} dsad_read_type;
  logic clk, reset, pc_step, pc_down, jump_take, vec_take, vec_alt, acc_valid, acc_write;
  logic acc_byte, mod_en, bitrev_en, y_valid, work_reg_load;
  logic [22:0] jump_addr;
  logic [22:0] pc = 23'h0;
  logic [6:0] vec_num;
  logic [15:0] source_pointer_reg, direct_addr, wr_data, mod_start, mod_end, bitrev_step, y_addr;
  dsad_src_type ea_src;
  dsad_mod_type post_mod;
  logic [15:0] prog_lo_data, prog_hi_data, special_func_reg_rdata, prog_view_rdata, ptr_out;
  logic [15:0] special_func_reg_addr, special_func_reg_wdata, x_rdata, y_rdata;
  logic [23:0] prog_lo_addr, prog_hi_addr, instr_word;
  logic [1:0] special_func_reg_be, work_reg_be;
  logic special_func_reg_hit, prog_view_sel, rd_valid, addr_err;
  logic [14:0] prog_view_addr;
  logic [2:0] pcops [8] = '{3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h4, 3'h2};
  logic [22:0] pcargs [8] = '{23'h0, 23'h0, 23'h0, 23'h001235, 23'h0, 23'h7d, 23'h3, 23'h0};
  logic [15:0] mem [int];
  logic [15:0] special_func_reg [16] = '{default: 16'h0};
  logic [31:0] seed = 32'd9652;
  int cyc = 0;
  int n_fail = 0;
  int checks = 0;
  dsad_step_type sq [$];
  dsad_read_type rq [$];
  dsad_step_type sm;
  dsad_read_type rm;

  dsad_decoder i_dut (.clk, .reset, .pc_step, .pc_down, .jump_take, .jump_addr, .vec_take,
    .vec_alt, .vec_num, .prog_lo_data, .prog_hi_data, .prog_lo_addr, .prog_hi_addr,
    .instr_word, .acc_valid, .acc_write, .acc_byte, .ea_src, .source_pointer_reg,
    .direct_addr, .wr_data, .post_mod, .mod_en, .mod_start, .mod_end, .bitrev_en,
    .bitrev_step, .ptr_out, .y_valid, .y_addr, .special_func_reg_rdata,
    .special_func_reg_hit, .special_func_reg_addr, .special_func_reg_wdata,
    .special_func_reg_be, .work_reg_load, .work_reg_be, .prog_view_rdata, .prog_view_sel,
    .prog_view_addr, .x_rdata, .y_rdata, .rd_valid, .addr_err);
  dsad_far_model i_far (.clk, .prog_lo_addr, .prog_hi_addr, .prog_lo_data, .prog_hi_data,
    .special_func_reg_addr, .special_func_reg_wdata, .special_func_reg_be,
    .special_func_reg_rdata, .special_func_reg_hit, .prog_view_sel, .prog_view_rdata);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  // Program word as the far side presents it, top byte dropped
  function automatic logic [23:0] pword(input logic [22:0] p);
    return {{p[7:1], 1'b1} ^ 8'h96, p[15:0] ^ 16'h3c5a};
  endfunction
  // Reverse-carry sum: carries run from the top bit down, done bit by bit
  function automatic logic [15:0] rc_add(input logic [15:0] p, q);
    logic c;
    c = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      rc_add[i] = p[i] ^ q[i] ^ c;
      c = (p[i] & q[i]) | (c & (p[i] ^ q[i]));
    end
  endfunction
  // Word seen at an even address, from the bench's own shadow of each region
  function automatic logic [15:0] rd_word(input logic [15:0] ea);
    if (ea[15]) return 16'h5a3c;
    if (ea >= `DSAD_DATA_TOP) return 16'h0000;
    if (ea >= `DSAD_SPECIAL_TOP) return mem[ea[15:1]];
    if (ea < 16'h0020) return special_func_reg[ea[4:1]];
    return 16'h0000;
  endfunction

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One request cycle; notes the expected results before the edge that takes it
  task automatic step(input logic av, wr, by, input dsad_src_type s, input logic [15:0] a, wd,
      input dsad_mod_type pm, input logic wl, yv, input logic [15:0] ya,
      input logic [2:0] pop, input logic [22:0] ja);
    logic [15:0] ea, w;
    logic mis;
    dsad_step_type st;
    dsad_read_type rn;
    @(posedge clk);
    ea = (s == SRC_NEAR) ? {3'h0, a[12:0]} : a;
    mis = av && !by && ea[0];
    st.stamp = cyc + 2;
    st.err = mis;
    st.cp = av && s == SRC_PTR;
    st.ptr = pm == MOD_INC ? a + {14'h0, !by, by} : pm == MOD_DEC ? a - {14'h0, !by, by} : a;
    if (mod_en && pm == MOD_INC && a >= mod_end) st.ptr = mod_start;
    if (mod_en && pm == MOD_DEC && a <= mod_start) st.ptr = mod_end;
    if (bitrev_en && wr && pm == MOD_INC) st.ptr = rc_add(a, bitrev_step);
    st.wbe = (av && wl) ? {!by, 1'b1} : 2'h0;
    st.pv = ea[14:0];
    st.sbe = by ? {ea[0], !ea[0]} : 2'h3;
    if (!(av && wr && !mis && ea < `DSAD_SPECIAL_TOP)) st.sbe = 2'h0;
    st.instr = pword(pc);
    case (pop)
      3'h1: pc = pc + 23'h2;
      3'h2: pc = pc - 23'h2;
      3'h3: pc = {ja[22:1], 1'b0};
      3'h4: pc = `DSAD_VEC_BASE + {15'h0, ja[6:0], 1'b0};
      3'h5: pc = `DSAD_VEC_ALT_BASE + {15'h0, ja[6:0], 1'b0};
      default: ;
    endcase
    st.lo = {1'b0, pc};
    sq.push_back(st);
    if (av && wr && !mis) begin
      w = by ? rd_word({ea[15:1], 1'b0}) : wd;
      if (by && ea[0]) w[15:8] = wd[7:0];
      else if (by) w[7:0] = wd[7:0];
      if (ea >= `DSAD_SPECIAL_TOP && ea < `DSAD_DATA_TOP) mem[ea[15:1]] = w;
      else if (ea < 16'h0020) special_func_reg[ea[4:1]] = w;
    end
    if ((av && !wr) || yv) begin
      w = rd_word({ea[15:1], 1'b0});
      rn.stamp = cyc + 3;
      rn.x = !(av && !wr) ? 16'h0 : !by ? w : ea[0] ? {8'h0, w[15:8]} : {8'h0, w[7:0]};
      rn.cy = yv;
      rn.y = (ya >= `DSAD_Y_BASE && ya < `DSAD_DATA_TOP) ? mem[ya[15:1]] : 16'h0;
      rq.push_back(rn);
    end
    acc_valid <= av;
    acc_write <= wr;
    acc_byte <= by;
    ea_src <= s;
    source_pointer_reg <= a;
    direct_addr <= a;
    wr_data <= wd;
    post_mod <= pm;
    work_reg_load <= wl;
    y_valid <= yv;
    y_addr <= ya;
    pc_step <= pop == 3'h1 || pop == 3'h2;
    pc_down <= pop == 3'h2;
    jump_take <= pop == 3'h3;
    vec_take <= pop[2];
    vec_alt <= pop == 3'h5;
    jump_addr <= ja;
    vec_num <= ja[6:0];
  endtask

  task automatic xa(input logic wr, by, input dsad_src_type s, input logic [15:0] a, wd,
      input dsad_mod_type pm = MOD_NONE, input logic wl = 1'b0);
    step(1'b1, wr, by, s, a, wd, pm, wl, 1'b0, 16'h0, 3'h0, 23'h0);
  endtask

  task automatic idle(input int n);
    repeat (n) step(1'b0, 1'b0, 1'b0, SRC_PTR, 16'h0, 16'h0, MOD_NONE, 1'b0, 1'b0, 16'h0,
      3'h0, 23'h0);
  endtask

  // Result watcher: takes the oldest note whenever its result is due or appears
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!reset && sq.size() > 0 && sq[0].stamp == cyc) begin
      sm = sq.pop_front();
      chk("addr_err", {23'h0, sm.err}, {23'h0, addr_err});
      chk("prog_lo_addr", sm.lo, prog_lo_addr);
      chk("prog_hi_addr", sm.lo | 24'h1, prog_hi_addr);
      chk("instr_word", sm.instr, instr_word);
      chk("work_reg_be", {22'h0, sm.wbe}, {22'h0, work_reg_be});
      if (sm.cp) chk("ptr_out", {8'h0, sm.ptr}, {8'h0, ptr_out});
      chk("prog_view_addr", {9'h0, sm.pv}, {9'h0, prog_view_addr});
      chk("special_func_reg_be", {22'h0, sm.sbe}, {22'h0, special_func_reg_be});
    end else if (!reset && addr_err !== 1'b0) chk("idle addr_err", 24'h0, 24'h1);
    if (rd_valid === 1'b1) begin
      rm = rq.pop_front();
      chk("read cycle", 24'(rm.stamp), 24'(cyc));
      chk("x_rdata", {8'h0, rm.x}, {8'h0, x_rdata});
      if (rm.cy) chk("y_rdata", {8'h0, rm.y}, {8'h0, y_rdata});
    end
    // Ceiling far above the 63 cycles the tests need; a hang ends here
    if (cyc == 2000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  initial begin
    logic [15:0] a;
    reset = 1'b1;
    {pc_step, pc_down, jump_take, vec_take, vec_alt, acc_valid, acc_write, acc_byte} = '0;
    {mod_en, bitrev_en, y_valid, work_reg_load, jump_addr, vec_num} = '0;
    {source_pointer_reg, direct_addr, wr_data, mod_start, mod_end, bitrev_step, y_addr} = '0;
    ea_src = SRC_PTR;
    post_mod = MOD_NONE;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    idle(2);
    // Program side: steps both ways, odd jump target, both vector tables
    foreach (pcops[i]) step(1'b0, 1'b0, 1'b0, SRC_PTR, 16'h0, 16'h0, MOD_NONE, 1'b0, 1'b0,
      16'h0, pcops[i], pcargs[i]);
    $display("program counter test done");
    // Random word writes each read straight back
    for (int i = 0; i < 8; i++) begin
      a = `DSAD_SPECIAL_TOP + (rnd() & 16'h6ffe);
      xa(1'b1, 1'b0, SRC_FAR, a, rnd());
      xa(1'b0, 1'b0, SRC_PTR, a, 16'h0, MOD_INC);
    end
    $display("random data test done");
    xa(1'b1, 1'b0, SRC_FAR, 16'h1100, 16'ha1b2);
    xa(1'b1, 1'b1, SRC_PTR, 16'h1101, rnd(), MOD_DEC);
    xa(1'b0, 1'b1, SRC_PTR, 16'h1100, 16'h0, MOD_INC, 1'b1);
    xa(1'b0, 1'b1, SRC_PTR, 16'h1101, 16'h0, MOD_DEC, 1'b1);
    xa(1'b0, 1'b0, SRC_PTR, 16'h1100, 16'h0, MOD_DEC, 1'b1);
    $display("byte lane test done");
    xa(1'b1, 1'b0, SRC_FAR, 16'h1101, 16'hffff);
    xa(1'b0, 1'b0, SRC_PTR, 16'h1101, 16'h0, MOD_INC);
    xa(1'b0, 1'b0, SRC_FAR, 16'h1100, 16'h0);
    $display("misaligned test done");
    xa(1'b0, 1'b0, SRC_FAR, 16'h7800, 16'h0);
    xa(1'b0, 1'b1, SRC_FAR, 16'h7ffd, 16'h0);
    xa(1'b0, 1'b0, SRC_NEAR, 16'he700, 16'h0);
    xa(1'b1, 1'b0, SRC_NEAR, 16'he010, 16'h1234);
    xa(1'b1, 1'b1, SRC_NEAR, 16'he013, 16'h00c9);
    idle(1);
    xa(1'b0, 1'b0, SRC_NEAR, 16'h2010, 16'h0);
    xa(1'b0, 1'b0, SRC_FAR, 16'h0012, 16'h0);
    xa(1'b0, 1'b0, SRC_FAR, 16'h8004, 16'h0);
    $display("region test done");
    xa(1'b1, 1'b0, SRC_FAR, 16'h4800, rnd());
    xa(1'b1, 1'b0, SRC_FAR, 16'h5002, rnd());
    step(1'b1, 1'b0, 1'b0, SRC_FAR, 16'h5002, 16'h0, MOD_NONE, 1'b0, 1'b1, 16'h4800, 3'h0,
      23'h0);
    step(1'b0, 1'b0, 1'b0, SRC_FAR, 16'h0, 16'h0, MOD_NONE, 1'b0, 1'b1, 16'h1100, 3'h0,
      23'h0);
    idle(1);
    $display("dual read test done");
    // Pointer modes: modulo wrap both ways, reverse carry on writes only
    mod_start <= 16'h1100;
    mod_end <= 16'h1104;
    mod_en <= 1'b1;
    xa(1'b1, 1'b0, SRC_PTR, 16'h1104, rnd(), MOD_INC);
    xa(1'b0, 1'b0, SRC_PTR, 16'h1100, 16'h0, MOD_DEC);
    bitrev_step <= 16'h0008;
    bitrev_en <= 1'b1;
    xa(1'b1, 1'b0, SRC_PTR, 16'h110c, rnd(), MOD_INC);
    xa(1'b0, 1'b0, SRC_PTR, 16'h1104, 16'h0, MOD_INC);
    idle(1);
    $display("address mode test done");
    repeat (5) @(posedge clk);
    if (rq.size() != 0 || sq.size() != 0) chk("pending notes", 24'h0, 24'h1);
    tally_and_finish();
  end
endmodule
